/* logic/eag_core.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - effective address is base plus scaled index plus displacement, unused parts omitted.
// - scale factors 1, 2, 4, 8 as index shift of zero to three.
// - 32-bit displacement is 8 or 32 bits; 8-bit is sign-extended.
// - any general register may serve as base.
// - stack pointer encoding in index field means no index.
// - address calculation adds no cycles, except base plus index adds one.
// - prefetched instruction bytes held in a sixteen-byte queue.
// - operands 8, 16 or 32 bits; 32-bit code 8/32, 16-bit code 8/16.
// - size override prefix swaps default operand length for one instruction.
// - zero to three operands, each from register, instruction or memory.
// - direct mode offset is the 8, 16 or 32-bit displacement alone.
// - register indirect offset is the base register content.
// - based mode offset is base register plus displacement.
// - index mode offset is index register plus displacement, scale one.
// - scaled index offset is scaled index plus displacement, no base.
// - linear address is segment base plus effective address.
// - protected mode system register access only at privilege zero, else fault.
// - in virtual-real mode flag push and pop checked against I/O privilege.
// - status word load writes low sixteen bits; store reads them.
// - wait instruction stalls while coprocessor busy is asserted.
// - immediate operand value comes from the instruction bytes.
// - status word load never clears protection enable; only full load does.
module eag_core #(
   parameter int QUEUE_DEPTH = eag_pkg::QUEUE_BYTES
) (
   // clock and reset
   input  wire logic                                         i_sys_clk,
   input  wire logic                                         i_nrst,
   // request from the decoder
   input  wire logic                                         i_req_valid,
   input  wire eag_pkg::eag_req_s                            i_req,
   output logic                                              o_req_ready,
   // register file and machine state
   input  wire logic [eag_pkg::GPR_COUNT-1:0][eag_pkg::XLEN-1:0] i_gpr,
   input  wire logic                                         i_code32,
   input  wire logic                                         i_protected,
   input  wire logic                                         i_v86,
   input  wire logic [1:0]                                   i_cpl,
   input  wire logic [1:0]                                   i_io_privilege_level,
   input  wire logic                                         i_copro_busy,
   // result toward segmentation and execution
   output logic                                              o_rsp_valid,
   output eag_pkg::eag_rsp_s                                 o_rsp,
   output logic [31:0]                                       o_cr0,
   // instruction byte prefetch
   input  wire logic                                         i_fetch_valid,
   input  wire logic [7:0]                                   i_fetch_byte,
   output logic                                              o_fetch_ready,
   output logic                                              o_instr_valid,
   output logic [7:0]                                        o_instr_byte,
   input  wire logic                                         i_instr_ready
);
   typedef enum logic [1:0] {
      S_IDLE,
      S_EXTRA,
      S_WAIT,
      S_CALC
   } eag_state_e;

   eag_state_e         state_reg;
   eag_state_e         state_next;
   eag_pkg::eag_req_s  req_reg;
   eag_pkg::eag_rsp_s  rsp_reg;
   logic               rsp_valid_reg;
   logic [31:0]        cr0_reg;
   logic [31:0]        cr0_next;

   // request decode for the incoming word
   wire accept      = i_req_valid && o_req_ready;
   wire in_base     = (i_req.mode == eag_pkg::MODE_BASE_INDEX) || (i_req.mode == eag_pkg::MODE_FULL);
   wire in_index_ok = (i_req.index_sel != eag_pkg::STACK_PTR_IDX);
   wire in_two_regs = in_base && in_index_ok;
   wire in_wait     = (i_req.sysop == eag_pkg::SYS_WAIT) && i_copro_busy;

   assign o_req_ready = (state_reg == S_IDLE);

   // component selection for the held request
   eag_pkg::eag_mode_e m;
   assign m = req_reg.mode;

   wire base_used  = (m == eag_pkg::MODE_REG_IND) || (m == eag_pkg::MODE_BASED) ||
                     (m == eag_pkg::MODE_BASE_INDEX) || (m == eag_pkg::MODE_FULL);
   wire index_mode = (m == eag_pkg::MODE_INDEX) || (m == eag_pkg::MODE_SCALED) ||
                     (m == eag_pkg::MODE_BASE_INDEX) || (m == eag_pkg::MODE_FULL);
   wire index_used = index_mode && (req_reg.index_sel != eag_pkg::STACK_PTR_IDX);
   wire disp_used  = (m == eag_pkg::MODE_DIRECT) || (m == eag_pkg::MODE_BASED) ||
                     (m == eag_pkg::MODE_INDEX) || (m == eag_pkg::MODE_SCALED) ||
                     (m == eag_pkg::MODE_FULL);
   wire mem_mode   = (m != eag_pkg::MODE_REG) && (m != eag_pkg::MODE_IMM);

   // plain index mode always uses a scale of one
   wire [1:0] scale_eff = (m == eag_pkg::MODE_INDEX) ? 2'h0 : req_reg.scale;

   logic [31:0] disp_ext;
   always_comb begin
      case (req_reg.disp_kind)
         eag_pkg::DISP_8:  disp_ext = {{24{req_reg.disp[7]}}, req_reg.disp[7:0]};
         eag_pkg::DISP_16: disp_ext = {16'h0, req_reg.disp[15:0]};
         eag_pkg::DISP_32: disp_ext = req_reg.disp;
         default:          disp_ext = 32'h0;
      endcase
   end

   wire [31:0] base_term  = base_used ? i_gpr[req_reg.base_sel] : 32'h0;
   wire [31:0] index_raw  = index_used ? i_gpr[req_reg.index_sel] : 32'h0;
   wire [31:0] index_term = index_raw << scale_eff;
   wire [31:0] disp_term  = disp_used ? disp_ext : 32'h0;
   // carry out of bit 31 is dropped on purpose
   wire [31:0] ea_sum     = base_term + index_term + disp_term;
   wire [31:0] linear_sum = req_reg.seg_base + ea_sum;

   // operand size from code default and prefix
   wire                  wide_default = i_code32 ^ req_reg.size_prefix;
   eag_pkg::eag_opsize_e opsize;
   assign opsize = req_reg.byte_op ? eag_pkg::SIZE_8 :
                   (wide_default ? eag_pkg::SIZE_32 : eag_pkg::SIZE_16);

   // privilege gating of system register access
   eag_pkg::eag_sysop_e op;
   assign op = req_reg.sysop;

   wire sys_priv   = (op == eag_pkg::SYS_CTRL_LOAD) || (op == eag_pkg::SYS_CTRL_STORE) ||
                     (op == eag_pkg::SYS_DBG_LOAD) || (op == eag_pkg::SYS_DBG_STORE) ||
                     (op == eag_pkg::SYS_TEST_LOAD) || (op == eag_pkg::SYS_TEST_STORE) ||
                     (op == eag_pkg::SYS_TABLE_LOAD) || (op == eag_pkg::SYS_CR0_FULL) ||
                     (op == eag_pkg::SYS_LOAD_STATUS_WORD_INSTRUCTION);
   wire priv_fault = i_protected && sys_priv && (i_cpl != eag_pkg::PRIV_KERNEL);
   wire flags_op   = (op == eag_pkg::SYS_FLAGS_PUSH) || (op == eag_pkg::SYS_FLAGS_POP);
   wire flag_fault = i_v86 && flags_op && (i_cpl > i_io_privilege_level);
   wire any_fault  = priv_fault || flag_fault;

   // operand source: register, instruction bytes or memory
   logic [31:0] operand_val;
   always_comb begin
      if (op == eag_pkg::SYS_STORE_STATUS_WORD_INSTRUCTION)
         operand_val = {16'h0, cr0_reg[eag_pkg::MSW_BITS-1:0]};
      else if (m == eag_pkg::MODE_REG)
         operand_val = i_gpr[req_reg.base_sel];
      else if (m == eag_pkg::MODE_IMM)
         operand_val = req_reg.imm;
      else
         operand_val = linear_sum;
   end

   // machine control register zero updates
   wire cr0_write = (state_reg == S_CALC) && !any_fault;
   always_comb begin
      cr0_next = cr0_reg;
      if (cr0_write && op == eag_pkg::SYS_CR0_FULL)
         cr0_next = req_reg.data;
      else if (cr0_write && op == eag_pkg::SYS_LOAD_STATUS_WORD_INSTRUCTION) begin
         cr0_next[eag_pkg::MSW_BITS-1:0] = req_reg.data[eag_pkg::MSW_BITS-1:0];
         cr0_next[eag_pkg::PE_BIT] = req_reg.data[eag_pkg::PE_BIT] | cr0_reg[eag_pkg::PE_BIT];
      end
   end

   // sequencing
   always_comb begin
      case (state_reg)
         S_IDLE: begin
            if (!accept)
               state_next = S_IDLE;
            else if (in_wait)
               state_next = S_WAIT;
            else if (in_two_regs)
               state_next = S_EXTRA;
            else
               state_next = S_CALC;
         end
         S_EXTRA: state_next = S_CALC;
         S_WAIT:  state_next = i_copro_busy ? S_WAIT : S_CALC;
         S_CALC:  state_next = S_IDLE;
         default: state_next = S_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_reg <= S_IDLE;
         req_reg   <= '0;
         cr0_reg   <= eag_pkg::CR0_RESET;
      end else begin
         state_reg <= state_next;
         cr0_reg   <= cr0_next;
         if (accept)
            req_reg <= i_req;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rsp_valid_reg <= 1'b0;
         rsp_reg       <= '0;
      end else begin
         rsp_valid_reg <= (state_reg == S_CALC);
         if (state_reg == S_CALC) begin
            rsp_reg.ea      <= mem_mode ? ea_sum : 32'h0;
            rsp_reg.linear  <= mem_mode ? linear_sum : 32'h0;
            rsp_reg.operand <= operand_val;
            rsp_reg.opsize  <= opsize;
            rsp_reg.fault   <= any_fault;
         end
      end
   end

   assign o_rsp_valid = rsp_valid_reg;
   assign o_rsp       = rsp_reg;
   assign o_cr0       = cr0_reg;

   eag_prefetch_queue #(
      .DEPTH (QUEUE_DEPTH),
      .WIDTH (8)
   ) u_queue (
      .i_sys_clk   (i_sys_clk),
      .i_nrst      (i_nrst),
      .i_in_valid  (i_fetch_valid),
      .i_in_data   (i_fetch_byte),
      .o_in_ready  (o_fetch_ready),
      .o_out_valid (o_instr_valid),
      .o_out_data  (o_instr_byte),
      .i_out_ready (i_instr_ready)
   );

   // checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);

   wire calc = (state_reg == S_CALC);

   a_single_cycle_ea: assert property (
      accept && !in_two_regs && !in_wait |=> !o_rsp_valid ##1 o_rsp_valid)
      else $error("simple address took the wrong number of cycles");

   a_base_index_extra: assert property (
      accept && in_two_regs && !in_wait |=> !o_rsp_valid [*2] ##1 o_rsp_valid)
      else $error("base plus index did not cost exactly one extra cycle");

   a_reg_indirect: assert property (
      calc && m == eag_pkg::MODE_REG_IND |=> o_rsp.ea == $past(i_gpr[req_reg.base_sel]))
      else $error("register indirect offset differs from base register");

   a_direct_sign: assert property (
      calc && m == eag_pkg::MODE_DIRECT && req_reg.disp_kind == eag_pkg::DISP_8
      |=> o_rsp.ea == {{24{$past(req_reg.disp[7])}}, $past(req_reg.disp[7:0])})
      else $error("8-bit displacement not sign-extended");

   a_no_stack_index: assert property (
      calc && (m == eag_pkg::MODE_INDEX || m == eag_pkg::MODE_SCALED) && req_reg.index_sel == eag_pkg::STACK_PTR_IDX
      && req_reg.disp_kind == eag_pkg::DISP_32 |=> o_rsp.ea == $past(req_reg.disp))
      else $error("stack pointer encoding used as an index");

   a_linear_sum: assert property (
      calc && mem_mode |=> o_rsp.linear == o_rsp.ea + $past(req_reg.seg_base))
      else $error("linear address is not segment base plus offset");

   a_priv_fault: assert property (
      calc && i_protected && sys_priv && i_cpl != eag_pkg::PRIV_KERNEL
      |=> o_rsp_valid && o_rsp.fault && $stable(o_cr0))
      else $error("system register access not refused above privilege zero");

   a_pe_sticky: assert property (
      calc && op == eag_pkg::SYS_LOAD_STATUS_WORD_INSTRUCTION && $past(o_cr0[eag_pkg::PE_BIT]) && o_cr0[eag_pkg::PE_BIT]
      |=> o_cr0[eag_pkg::PE_BIT])
      else $error("status word load cleared protection enable");

   a_msw_high_kept: assert property (
      calc && op == eag_pkg::SYS_LOAD_STATUS_WORD_INSTRUCTION |=> o_cr0[31:16] == $past(o_cr0[31:16]))
      else $error("status word load touched the upper half");

   a_wait_stall: assert property (
      state_reg == S_WAIT && i_copro_busy |=> state_reg == S_WAIT && !o_rsp_valid)
      else $error("wait left the stall while coprocessor busy");

   a_prefix_size: assert property (
      calc && !req_reg.byte_op && !i_code32 && req_reg.size_prefix |=> o_rsp.opsize == eag_pkg::SIZE_32)
      else $error("size prefix did not widen 16-bit code operand");

   a_scaled_index: assert property (
      calc && m == eag_pkg::MODE_SCALED && req_reg.index_sel != eag_pkg::STACK_PTR_IDX &&
      req_reg.disp_kind == eag_pkg::DISP_32
      |=> o_rsp.ea == ($past(i_gpr[req_reg.index_sel]) << $past(req_reg.scale)) + $past(req_reg.disp))
      else $error("scaled index offset is not scaled index plus displacement");

   a_imm_operand: assert property (
      calc && m == eag_pkg::MODE_IMM && op == eag_pkg::SYS_NONE |=> o_rsp.operand == $past(req_reg.imm))
      else $error("immediate operand not taken from the instruction");

   a_flags_io_privilege_level: assert property (
      calc && i_v86 && flags_op && i_cpl > i_io_privilege_level |=> o_rsp_valid && o_rsp.fault)
      else $error("flag push or pop not refused above the I/O privilege level");

   a_msw_read: assert property (
      calc && op == eag_pkg::SYS_STORE_STATUS_WORD_INSTRUCTION |=> o_rsp.operand == {16'h0, $past(o_cr0[eag_pkg::MSW_BITS-1:0])})
      else $error("status word store did not return the low half");

   a_kernel_no_fault: assert property (
      calc && !i_v86 && (!i_protected || i_cpl == eag_pkg::PRIV_KERNEL) |=> !o_rsp.fault)
      else $error("access faulted although it was permitted");

   c_base_index: cover property (accept && in_two_regs ##3 o_rsp_valid);
   c_wait_stall: cover property (state_reg == S_WAIT ##1 state_reg == S_WAIT ##1 calc);
   c_priv_fault: cover property (o_rsp_valid && o_rsp.fault);
   c_direct_disp8: cover property (calc && m == eag_pkg::MODE_DIRECT && req_reg.disp_kind == eag_pkg::DISP_8);

endmodule

/* logic/eag_pkg.sv */
package eag_pkg;

   localparam int          XLEN          = 32;
   localparam int          GPR_COUNT     = 8;
   localparam int          QUEUE_BYTES   = 16;
   localparam int          MAX_OPERANDS  = 3;
   localparam logic [2:0]  STACK_PTR_IDX = 3'h4;
   localparam int          PE_BIT        = 0;
   localparam int          MSW_BITS      = 16;
   localparam logic [31:0] CR0_RESET     = 32'h0;
   localparam logic [1:0]  PRIV_KERNEL   = 2'h0;

   // operand addressing modes
   typedef enum logic [3:0] {
      MODE_REG,
      MODE_IMM,
      MODE_DIRECT,
      MODE_REG_IND,
      MODE_BASED,
      MODE_INDEX,
      MODE_SCALED,
      MODE_BASE_INDEX,
      MODE_FULL
   } eag_mode_e;

   typedef enum logic [1:0] {
      DISP_NONE,
      DISP_8,
      DISP_16,
      DISP_32
   } eag_disp_e;

   typedef enum logic [1:0] {
      SIZE_8,
      SIZE_16,
      SIZE_32
   } eag_opsize_e;

   // system side effects carried with a request
   typedef enum logic [3:0] {
      SYS_NONE,
      SYS_CTRL_LOAD,
      SYS_CTRL_STORE,
      SYS_DBG_LOAD,
      SYS_DBG_STORE,
      SYS_TEST_LOAD,
      SYS_TEST_STORE,
      SYS_TABLE_LOAD,
      SYS_CR0_FULL,
      SYS_LOAD_STATUS_WORD_INSTRUCTION,
      SYS_STORE_STATUS_WORD_INSTRUCTION,
      SYS_FLAGS_PUSH,
      SYS_FLAGS_POP,
      SYS_WAIT
   } eag_sysop_e;

   typedef struct packed {
      eag_mode_e   mode;
      logic [1:0]  operand_count;
      logic [2:0]  base_sel;
      logic [2:0]  index_sel;
      logic [1:0]  scale;
      eag_disp_e   disp_kind;
      logic [31:0] disp;
      logic [31:0] imm;
      logic [31:0] seg_base;
      logic        byte_op;
      logic        size_prefix;
      eag_sysop_e  sysop;
      logic [31:0] data;
   } eag_req_s;

   typedef struct packed {
      logic [31:0] ea;
      logic [31:0] linear;
      logic [31:0] operand;
      eag_opsize_e opsize;
      logic        fault;
   } eag_rsp_s;

endpackage

/* logic/eag_prefetch_queue.sv */
`timescale 1ns/1ns
module eag_prefetch_queue #(
   parameter int DEPTH = eag_pkg::QUEUE_BYTES,
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_nrst,
   // fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // drain side
   output logic                  o_out_valid,
   output logic [WIDTH-1:0]      o_out_data,
   input  wire logic             i_out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [DEPTH-1:0][WIDTH-1:0] mem_reg;
   logic [AW-1:0]               wr_ptr_reg;
   logic [AW-1:0]               rd_ptr_reg;
   logic [AW:0]                 count_reg;
   wire                         push = i_in_valid && o_in_ready;
   wire                         pop  = o_out_valid && i_out_ready;

   assign o_in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign o_out_valid = (count_reg != '0);
   assign o_out_data  = mem_reg[rd_ptr_reg];

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_entry
         always_ff @(posedge i_sys_clk or negedge i_nrst) begin
            if (!i_nrst)
               mem_reg[g] <= '0;
            else if (push && wr_ptr_reg == AW'(g))
               mem_reg[g] <= i_in_data;
         end
      end
   endgenerate

   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push)
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   a_queue_capacity: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      (count_reg == (AW+1)'(DEPTH)) && !pop |=> (count_reg == (AW+1)'(DEPTH)) && $stable(mem_reg))
      else $error("full prefetch queue took another byte");
   c_queue_full: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) !o_in_ready);

endmodule

/* sim/eag_copro_model.sv */
`timescale 1ns/1ns
module eag_copro_model (
   // clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_nrst,
   // command from the bench
   input  wire logic       i_start,
   input  wire logic [7:0] i_cycles,
   // busy toward the core
   output logic            o_busy
);
   logic [7:0] left_reg;

   // busy stays high through every cycle that the operation is still running
   assign o_busy = (left_reg != 8'h0);

   // changes on the falling edge so the core never samples a moving level
   always @(negedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         left_reg <= 8'h0;
      end else if (i_start) begin
         left_reg <= i_cycles;
      end else if (left_reg != 8'h0) begin
         left_reg <= left_reg - 8'h1;
      end
   end
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   localparam logic [31:0] SEG = 32'h0010_0000;
   logic sys_clk, nrst, req_valid, req_ready, rsp_valid, code32, prot, v86, busy, start;
   logic fetch_valid, fetch_ready, instr_valid, instr_ready;
   logic [1:0] cpl, io_privilege_level;
   logic [7:0] fetch_byte, instr_byte, cyc;
   logic [31:0] cr0;
   logic [eag_pkg::GPR_COUNT-1:0][eag_pkg::XLEN-1:0] gpr;
   eag_pkg::eag_req_s req;
   eag_pkg::eag_rsp_s rsp_w, rsp;
   int n_errors = 0;
   int compares = 0;
   int lat;

   eag_core dut (.i_sys_clk(sys_clk), .i_nrst(nrst), .i_req_valid(req_valid), .i_req(req),
      .o_req_ready(req_ready), .i_gpr(gpr), .i_code32(code32), .i_protected(prot), .i_v86(v86),
      .i_cpl(cpl), .i_io_privilege_level(io_privilege_level), .i_copro_busy(busy), .o_rsp_valid(rsp_valid),
      .o_rsp(rsp_w), .o_cr0(cr0), .i_fetch_valid(fetch_valid), .i_fetch_byte(fetch_byte),
      .o_fetch_ready(fetch_ready), .o_instr_valid(instr_valid), .o_instr_byte(instr_byte),
      .i_instr_ready(instr_ready));
   eag_copro_model copro (.i_sys_clk(sys_clk), .i_nrst(nrst), .i_start(start), .i_cycles(cyc), .o_busy(busy));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic conclude;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic eag_pkg::eag_req_s mk(input eag_pkg::eag_mode_e m, input logic [2:0] b,
      input logic [2:0] x, input logic [1:0] s, input eag_pkg::eag_disp_e dk, input logic [31:0] d);
      eag_pkg::eag_req_s r;
      r = '0;
      r.mode = m;
      r.operand_count = 2'h1;
      r.base_sel = b;
      r.index_sel = x;
      r.scale = s;
      r.disp_kind = dk;
      r.disp = d;
      r.seg_base = SEG;
      return r;
   endfunction

   // hold the request until taken, then count edges up to the response
   task automatic do_req(input eag_pkg::eag_req_s r);
      int n;
      n = 0;
      @(negedge sys_clk);
      req = r;
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      if (req_ready !== 1'b1)
         chk({31'h0, req_ready}, 32'h1);
      @(negedge sys_clk);
      req_valid = 1'b0;
      lat = 1;
      while (rsp_valid !== 1'b1 && lat < 50) begin
         @(negedge sys_clk);
         lat++;
      end
      if (rsp_valid !== 1'b1)
         chk({31'h0, rsp_valid}, 32'h1);
      rsp = rsp_w;
   endtask

   task automatic ea_case(input eag_pkg::eag_req_s r, input logic [31:0] exp, input int exp_lat);
      do_req(r);
      chk(rsp.ea, exp);
      chk(rsp.linear, exp + SEG);
      chk(32'(lat), 32'(exp_lat));
   endtask

   task automatic t_direct;
      ea_case(mk(eag_pkg::MODE_DIRECT, 3'h0, 3'h0, 2'h0, eag_pkg::DISP_8, 32'h0000_00f0), 32'hffff_fff0, 2);
      ea_case(mk(eag_pkg::MODE_DIRECT, 3'h0, 3'h0, 2'h0, eag_pkg::DISP_8, 32'h0000_0070), 32'h0000_0070, 2);
      ea_case(mk(eag_pkg::MODE_DIRECT, 3'h0, 3'h0, 2'h0, eag_pkg::DISP_16, 32'h0001_8000), 32'h0000_8000, 2);
      ea_case(mk(eag_pkg::MODE_DIRECT, 3'h0, 3'h0, 2'h0, eag_pkg::DISP_32, 32'h89ab_cdef), 32'h89ab_cdef, 2);
   endtask

   task automatic t_base;
      for (int i = 0; i < 8; i++) begin
         ea_case(mk(eag_pkg::MODE_REG_IND, 3'(i), 3'h0, 2'h0, eag_pkg::DISP_NONE, 32'h0), gpr[i], 2);
      end
      ea_case(mk(eag_pkg::MODE_BASED, 3'h4, 3'h0, 2'h0, eag_pkg::DISP_8, 32'h0000_0080), gpr[4] - 32'h80, 2);
   endtask

   task automatic t_index;
      ea_case(mk(eag_pkg::MODE_INDEX, 3'h0, 3'h3, 2'h3, eag_pkg::DISP_32, 32'h0000_0010), gpr[3] + 32'h10, 2);
      for (int s = 0; s < 4; s++) begin
         ea_case(mk(eag_pkg::MODE_SCALED, 3'h1, 3'h5, 2'(s), eag_pkg::DISP_32, 32'h0000_0100),
            (gpr[5] << s) + 32'h100, 2);
      end
      ea_case(mk(eag_pkg::MODE_SCALED, 3'h1, 3'h4, 2'h3, eag_pkg::DISP_32, 32'h0000_0100), 32'h100, 2);
   endtask

   task automatic t_full;
      ea_case(mk(eag_pkg::MODE_FULL, 3'h1, 3'h2, 2'h2, eag_pkg::DISP_32, 32'hffff_fff0),
         gpr[1] + (gpr[2] << 2) + 32'hffff_fff0, 3);
      ea_case(mk(eag_pkg::MODE_BASE_INDEX, 3'h7, 3'h6, 2'h0, eag_pkg::DISP_NONE, 32'h0), gpr[7] + gpr[6], 3);
      ea_case(mk(eag_pkg::MODE_BASE_INDEX, 3'h7, 3'h4, 2'h0, eag_pkg::DISP_NONE, 32'h0), gpr[7], 2);
   endtask

   task automatic t_size;
      eag_pkg::eag_req_s r;
      eag_pkg::eag_opsize_e e;
      for (int k = 0; k < 8; k++) begin
         r = mk(eag_pkg::MODE_REG, 3'(k), 3'h0, 2'h0, eag_pkg::DISP_NONE, 32'h0);
         r.operand_count = 2'h3;
         r.byte_op = k[0];
         r.size_prefix = k[1];
         code32 = k[2];
         e = k[0] ? eag_pkg::SIZE_8 : ((k[1] ^ k[2]) ? eag_pkg::SIZE_32 : eag_pkg::SIZE_16);
         do_req(r);
         chk({30'h0, rsp.opsize}, {30'h0, e});
         chk(rsp.operand, gpr[k]);
         chk(rsp.linear, 32'h0);
      end
      r.mode = eag_pkg::MODE_IMM;
      r.imm = 32'h5a5a_c3c3;
      do_req(r);
      chk(rsp.operand, 32'h5a5a_c3c3);
   endtask

   task automatic sys_req(input eag_pkg::eag_sysop_e op, input logic [31:0] d, input logic flt);
      eag_pkg::eag_req_s r;
      r = mk(eag_pkg::MODE_REG, 3'h0, 3'h0, 2'h0, eag_pkg::DISP_NONE, 32'h0);
      r.sysop = op;
      r.data = d;
      do_req(r);
      chk({31'h0, rsp.fault}, {31'h0, flt});
   endtask

   task automatic t_priv;
      eag_pkg::eag_sysop_e ops [9];
      ops = '{eag_pkg::SYS_CTRL_LOAD, eag_pkg::SYS_CTRL_STORE, eag_pkg::SYS_DBG_LOAD, eag_pkg::SYS_DBG_STORE,
         eag_pkg::SYS_TEST_LOAD, eag_pkg::SYS_TEST_STORE, eag_pkg::SYS_TABLE_LOAD, eag_pkg::SYS_CR0_FULL,
         eag_pkg::SYS_LOAD_STATUS_WORD_INSTRUCTION};
      prot = 1'b1;
      cpl = 2'h3;
      foreach (ops[i]) begin
         sys_req(ops[i], 32'hffff_ffff, 1'b1);
         chk(cr0, eag_pkg::CR0_RESET);
      end
      cpl = 2'h0;
      sys_req(eag_pkg::SYS_CR0_FULL, 32'h8000_0001, 1'b0);
      chk(cr0, 32'h8000_0001);
   endtask

   task automatic t_msw;
      sys_req(eag_pkg::SYS_LOAD_STATUS_WORD_INSTRUCTION, 32'h1234_fffe, 1'b0);
      chk(cr0, 32'h8000_ffff);
      sys_req(eag_pkg::SYS_STORE_STATUS_WORD_INSTRUCTION, 32'h0, 1'b0);
      chk(rsp.operand, 32'h0000_ffff);
      sys_req(eag_pkg::SYS_CR0_FULL, 32'h0, 1'b0);
      chk(cr0, 32'h0);
      prot = 1'b0;
      cpl = 2'h3;
      sys_req(eag_pkg::SYS_LOAD_STATUS_WORD_INSTRUCTION, 32'hffff_0001, 1'b0);
      chk(cr0, 32'h0000_0001);
   endtask

   task automatic t_flags;
      v86 = 1'b1;
      prot = 1'b1;
      cpl = 2'h3;
      io_privilege_level = 2'h0;
      sys_req(eag_pkg::SYS_FLAGS_PUSH, 32'h0, 1'b1);
      sys_req(eag_pkg::SYS_FLAGS_POP, 32'h0, 1'b1);
      io_privilege_level = 2'h3;
      sys_req(eag_pkg::SYS_FLAGS_PUSH, 32'h0, 1'b0);
      sys_req(eag_pkg::SYS_FLAGS_POP, 32'h0, 1'b0);
      v86 = 1'b0;
      prot = 1'b0;
   endtask

   // the take edge already sees busy; the answer follows the first edge that sees it low
   task automatic t_wait;
      cyc = 8'h6;
      @(negedge sys_clk);
      start <= 1'b1;
      @(negedge sys_clk);
      start <= 1'b0;
      sys_req(eag_pkg::SYS_WAIT, 32'h0, 1'b0);
      chk(32'(lat), 32'd7);
      sys_req(eag_pkg::SYS_WAIT, 32'h0, 1'b0);
      chk(32'(lat), 32'd2);
   endtask

   task automatic t_queue;
      for (int k = 0; k < 17; k++) begin
         @(negedge sys_clk);
         chk({31'h0, fetch_ready}, {31'h0, k < 16});
         fetch_valid = 1'b1;
         fetch_byte = (k < 16) ? 8'(8'h30 + k) : 8'hee;
      end
      @(negedge sys_clk);
      fetch_valid = 1'b0;
      chk({31'h0, fetch_ready}, 32'h0);
      for (int k = 0; k < 16; k++) begin
         chk({24'h0, instr_byte}, 32'(8'h30 + k));
         instr_ready = 1'b1;
         @(negedge sys_clk);
      end
      instr_ready = 1'b0;
      chk({31'h0, instr_valid}, 32'h0);
   endtask

   initial begin
      nrst = 1'b0;
      req_valid = 1'b0;
      req = '0;
      code32 = 1'b1;
      prot = 1'b0;
      v86 = 1'b0;
      cpl = 2'h0;
      io_privilege_level = 2'h0;
      start = 1'b0;
      cyc = 8'h0;
      fetch_valid = 1'b0;
      fetch_byte = 8'h0;
      instr_ready = 1'b0;
      for (int i = 0; i < 8; i++) begin
         gpr[i] = 32'h0100_0010 * (i + 1);
      end
      repeat (21) @(negedge sys_clk);
      nrst = 1'b1;
      @(negedge sys_clk);
      chk(cr0, eag_pkg::CR0_RESET);
      chk({30'h0, req_ready, instr_valid}, 32'h2);
      t_direct;
      t_base;
      t_index;
      t_full;
      t_size;
      t_priv;
      t_msw;
      t_flags;
      t_wait;
      t_queue;
      conclude;
   end

   initial begin
      #200000;
      n_errors++;
      conclude;
   end
endmodule
